// *** mifd_params.svh ***
// Offsets, field positions, reset values and timing counts of the decoder.
`ifndef MIFD_PARAMS_SVH
`define MIFD_PARAMS_SVH

// Register byte offsets on the APB.
`define MIFD_OFF_INSTR   12'h000
`define MIFD_OFF_OPERAND 12'h004
`define MIFD_OFF_ACC     12'h008
`define MIFD_OFF_BANK    12'h00c
`define MIFD_OFF_FLAGS   12'h010
`define MIFD_OFF_DECODE  12'h014
`define MIFD_OFF_ADDR    12'h018
`define MIFD_OFF_TARGET  12'h01c
`define MIFD_OFF_RESULT  12'h020
`define MIFD_OFF_PROGRAM_TABLE_POINTER  12'h024
`define MIFD_OFF_TBLLAT  12'h028

// Instruction field positions.
`define MIFD_OPC_HI      15
`define MIFD_DEST_BIT    9
`define MIFD_ACC_BIT     8
`define MIFD_BIT_HI      11
`define MIFD_BIT_LO      9
`define MIFD_FAST_BIT    8
`define MIFD_SECOND_TAG  4'hf

// Access bank split: low file addresses map to bank 0, high ones to bank 15.
`define MIFD_ACC_SPLIT   8'h80
`define MIFD_ACC_LOW     4'h0
`define MIFD_ACC_HIGH    4'hf

// Reset values.
`define MIFD_RST_BYTE    8'h00
`define MIFD_RST_BANK    4'h0
`define MIFD_RST_PTR     21'h000000

// Instruction cycle counts.
`define MIFD_CYC_ONE     2'h1
`define MIFD_CYC_TWO     2'h2

`endif

// *** mifd_pkg.sv ***
// Types shared by the instruction format decoder.
package mifd_pkg;

   // Sequencing of one- and two-word instructions.
   typedef enum logic {
      MIFD_IDLE,
      MIFD_WAIT2
   } mifd_state_e;

   // Instruction classes that the decoder recognises.
   typedef enum logic [4:0] {
      OP_OTHER,
      OP_ADD,
      OP_ADDC,
      OP_DEC,
      OP_DECSZ,
      OP_DECSNZ,
      OP_INC,
      OP_INCSZ,
      OP_INCSNZ,
      OP_CPEQ,
      OP_CPGT,
      OP_CPLT,
      OP_CLR,
      OP_MOVE,
      OP_CALL,
      OP_GOTO,
      OP_JUMP,
      OP_BCOND,
      OP_SECOND
   } mifd_op_e;

   // ALU status flags.
   typedef struct packed {
      logic n;
      logic ov;
      logic z;
      logic dc;
      logic c;
   } mifd_flags_s;

   // Fields split out of one instruction word.
   typedef struct packed {
      mifd_op_e   op;
      logic       dest;
      logic       bank_acc;
      logic [2:0] bitpos;
      logic [7:0] faddr;
      logic [7:0] literal;
   } mifd_dec_s;

endpackage

// *** mifd_decoder.sv ***
// Instruction format decoder and byte-operation unit behind an APB slave.
//
// Added by the designer: the register addresses and the APB register port.
`timescale 1ns/100ps
`include "mifd_params.svh"

// How it works
// - Byte ops: opcode, dest, access, file fields.
// - Access bit 0 forces access bank, else bank.
// - File field is 8-bit address within bank.
// - Move carries 12-bit source, 12-bit destination.
// - Bit ops: bit position, access, file fields.
// - Literal ops take 8-bit immediate, low byte.
// - Call and goto form 20-bit target.
// - Call fast bit selects shadow save.
// - Unconditional jump takes 11-bit signed offset.
// - Conditional branches take 8-bit signed offset.
// - Don't-care encoding bits are ignored.
// - 21-bit table pointer and 8-bit table latch.
// - Add and add-with-carry update all five flags.
// - Five flags, changed only when listed, and Z by clear.
// - Compares skip on equal, greater, less.
// - Decrement sets flags; decrement-skip-zero keeps them.
// - Decrement, skip when non-zero, no flags.
// - Increment sets flags; increment-skip-zero keeps them.
// - Increment, skip when non-zero, no flags.
// - Dest 0 to accumulator, 1 to file.
// - Lone second word executes as no-operation.
// - One cycle; skip, jump or a two-word pair adds one.
module mifd_decoder
   import mifd_pkg::*;
(
   // Clock and reset.
   input  wire logic        clock,
   input  wire logic        sys_rst,
   // APB slave.
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // File register write port toward the data memory.
   output logic             file_wr_strobe,
   output logic      [11:0] file_wr_addr,
   output logic      [7:0]  file_wr_data,
   // Next instruction is to be discarded.
   output logic             skip_next
);

   // Software-visible state.
   logic [15:0]  instr_word;
   logic [15:0]  first_word;
   logic         exec_go;
   logic [7:0]   operand;
   logic [7:0]   working_accumulator;
   logic [3:0]   bank_select_reg;
   mifd_flags_s  flags;
   logic [20:0]  program_table_pointer;
   logic [7:0]   program_table_latch;
   mifd_state_e  state;

   // Captured results of the last executed instruction.
   mifd_dec_s    dec_q;
   logic [11:0]  addr_q;
   logic [11:0]  move_dst_q;
   logic [20:0]  target_q;
   logic         fast_q;
   logic [7:0]   result_q;
   logic         taken_q;
   logic [1:0]   cycles_q;
   logic         second_bad_q;

   // Combinational decode and execute.
   mifd_dec_s    dec;
   logic [11:0]  eff_addr;
   logic [8:0]   sum;
   logic [4:0]   low_sum;
   logic [7:0]   alu_a;
   logic [7:0]   alu_b;
   logic         alu_cin;
   logic [7:0]   next_result;
   mifd_flags_s  next_flags;
   logic         next_skip;
   logic         next_taken;
   logic         next_to_file;
   logic         next_to_acc;
   logic         cond_flag;
   logic         two_word;
   logic         wr_en;
   logic         addr_ok;

   // The bus never waits, so every access completes in its access phase.
   assign pready = 1'b1;
   assign wr_en  = psel & penable & pwrite;

   // Field split; bits outside the fields of a class never steer it.
   always_comb begin
      dec.dest     = instr_word[`MIFD_DEST_BIT];
      dec.bank_acc = instr_word[`MIFD_ACC_BIT];
      dec.bitpos   = instr_word[`MIFD_BIT_HI:`MIFD_BIT_LO];
      dec.faddr    = instr_word[7:0];
      dec.literal  = instr_word[7:0];
      casez (instr_word[`MIFD_OPC_HI:8])
         8'b0010_01??: dec.op = OP_ADD;
         8'b0010_00??: dec.op = OP_ADDC;
         8'b0000_01??: dec.op = OP_DEC;
         8'b0010_11??: dec.op = OP_DECSZ;
         8'b0100_11??: dec.op = OP_DECSNZ;
         8'b0010_10??: dec.op = OP_INC;
         8'b0011_11??: dec.op = OP_INCSZ;
         8'b0100_10??: dec.op = OP_INCSNZ;
         8'b0110_001?: dec.op = OP_CPEQ;
         8'b0110_010?: dec.op = OP_CPGT;
         8'b0110_000?: dec.op = OP_CPLT;
         8'b0110_101?: dec.op = OP_CLR;
         8'b1100_????: dec.op = OP_MOVE;
         8'b1110_110?: dec.op = OP_CALL;
         8'b1110_1111: dec.op = OP_GOTO;
         8'b1101_0???: dec.op = OP_JUMP;
         8'b1110_0???: dec.op = OP_BCOND;
         8'b1111_????: dec.op = OP_SECOND;
         default:      dec.op = OP_OTHER;
      endcase
   end

   assign two_word = (dec.op == OP_MOVE) || (dec.op == OP_CALL)
                     || (dec.op == OP_GOTO);

   // Bank resolution; the access bank splits the page into low and high.
   always_comb begin
      if (dec.bank_acc) begin
         eff_addr = {bank_select_reg, dec.faddr};
      end else if (dec.faddr < `MIFD_ACC_SPLIT) begin
         eff_addr = {`MIFD_ACC_LOW, dec.faddr};
      end else begin
         eff_addr = {`MIFD_ACC_HIGH, dec.faddr};
      end
   end

   // Operand selection for the shared adder.
   always_comb begin
      alu_a   = operand;
      alu_b   = `MIFD_RST_BYTE;
      alu_cin = 1'b0;
      unique case (dec.op)
         OP_ADD: begin
            alu_a = working_accumulator;
            alu_b = operand;
         end
         OP_ADDC: begin
            alu_a   = working_accumulator;
            alu_b   = operand;
            alu_cin = flags.c;
         end
         OP_DEC, OP_DECSZ, OP_DECSNZ: begin
            alu_b = 8'hff;
         end
         OP_INC, OP_INCSZ, OP_INCSNZ: begin
            alu_cin = 1'b1;
         end
         default: begin
            alu_a = operand;
         end
      endcase
   end

   // One adder serves add, increment and decrement; DC comes from bit 3.
   assign low_sum = {1'b0, alu_a[3:0]} + {1'b0, alu_b[3:0]}
                    + {4'h0, alu_cin};
   assign sum     = {1'b0, alu_a} + {1'b0, alu_b} + {8'h00, alu_cin};

   // Branch condition: bits 10..9 pick the flag, bit 8 inverts it.
   always_comb begin
      unique case (instr_word[10:9])
         2'h0: cond_flag = flags.z;
         2'h1: cond_flag = flags.c;
         2'h2: cond_flag = flags.ov;
         2'h3: cond_flag = flags.n;
      endcase
   end

   // Result, flags, skip and destination of the word in hand.
   always_comb begin
      next_result  = sum[7:0];
      next_flags   = flags;
      next_skip    = 1'b0;
      next_taken   = 1'b0;
      next_to_file = 1'b0;
      next_to_acc  = 1'b0;
      unique case (dec.op)
         OP_ADD, OP_ADDC, OP_DEC, OP_INC: begin
            next_flags.c  = sum[8];
            next_flags.dc = low_sum[4];
            next_flags.z  = (sum[7:0] == 8'h00);
            next_flags.n  = sum[7];
            next_flags.ov = (alu_a[7] == alu_b[7])
                            && (sum[7] != alu_a[7]);
            next_to_file  = dec.dest;
            next_to_acc   = ~dec.dest;
         end
         OP_DECSZ, OP_INCSZ: begin
            next_skip    = (sum[7:0] == 8'h00);
            next_to_file = dec.dest;
            next_to_acc  = ~dec.dest;
         end
         OP_DECSNZ, OP_INCSNZ: begin
            next_skip    = (sum[7:0] != 8'h00);
            next_to_file = dec.dest;
            next_to_acc  = ~dec.dest;
         end
         OP_CPEQ: next_skip = (operand == working_accumulator);
         OP_CPGT: next_skip = (operand > working_accumulator);
         OP_CPLT: next_skip = (operand < working_accumulator);
         OP_CLR: begin
            next_result  = `MIFD_RST_BYTE;
            next_flags.z = 1'b1;
            next_to_file = 1'b1;
         end
         OP_JUMP:  next_taken = 1'b1;
         OP_BCOND: next_taken = cond_flag ^ instr_word[8];
         default:  next_result = sum[7:0];
      endcase
   end

   // A write to the instruction register launches execution next cycle.
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         instr_word <= 16'h0000;
         exec_go    <= 1'b0;
      end else begin
         exec_go <= wr_en && (paddr == `MIFD_OFF_INSTR);
         if (wr_en && (paddr == `MIFD_OFF_INSTR)) begin
            instr_word <= pwdata[15:0];
         end
      end
   end

   // Plain software registers; the table pair is only stored here.
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         operand               <= `MIFD_RST_BYTE;
         bank_select_reg       <= `MIFD_RST_BANK;
         program_table_pointer <= `MIFD_RST_PTR;
         program_table_latch   <= `MIFD_RST_BYTE;
      end else if (wr_en) begin
         if (paddr == `MIFD_OFF_OPERAND) begin
            operand <= pwdata[7:0];
         end
         if (paddr == `MIFD_OFF_BANK) begin
            bank_select_reg <= pwdata[3:0];
         end
         if (paddr == `MIFD_OFF_PROGRAM_TABLE_POINTER) begin
            program_table_pointer <= pwdata[20:0];
         end
         if (paddr == `MIFD_OFF_TBLLAT) begin
            program_table_latch <= pwdata[7:0];
         end
      end
   end

   // Accumulator and flags change on execution or on a software write.
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         working_accumulator <= `MIFD_RST_BYTE;
         flags               <= '0;
      end else if (exec_go && (state == MIFD_IDLE)) begin
         flags <= next_flags;
         if (next_to_acc) begin
            working_accumulator <= next_result;
         end
      end else if (wr_en) begin
         if (paddr == `MIFD_OFF_ACC) begin
            working_accumulator <= pwdata[7:0];
         end
         if (paddr == `MIFD_OFF_FLAGS) begin
            flags <= pwdata[4:0];
         end
      end
   end

   // Two-word sequencing: the first word waits for its companion.
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         state      <= MIFD_IDLE;
         first_word <= 16'h0000;
      end else if (exec_go) begin
         unique case (state)
            MIFD_IDLE: begin
               if (two_word) begin
                  state      <= MIFD_WAIT2;
                  first_word <= instr_word;
               end
            end
            MIFD_WAIT2: state <= MIFD_IDLE;
         endcase
      end
   end

   // Capture of the executed instruction for readback and the write port.
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         dec_q          <= '0;
         addr_q         <= 12'h000;
         move_dst_q     <= 12'h000;
         target_q       <= `MIFD_RST_PTR;
         fast_q         <= 1'b0;
         result_q       <= `MIFD_RST_BYTE;
         taken_q        <= 1'b0;
         cycles_q       <= `MIFD_CYC_ONE;
         second_bad_q   <= 1'b0;
         skip_next      <= 1'b0;
         file_wr_strobe <= 1'b0;
         file_wr_addr   <= 12'h000;
         file_wr_data   <= `MIFD_RST_BYTE;
      end else begin
         file_wr_strobe <= 1'b0;
         if (exec_go && (state == MIFD_WAIT2)) begin
            // Second word: its low twelve bits complete the first.
            second_bad_q <= (instr_word[15:12] != `MIFD_SECOND_TAG);
            cycles_q     <= `MIFD_CYC_TWO;
            skip_next    <= 1'b0;
            taken_q      <= (first_word[15:12] != 4'hc);
            if (first_word[15:12] == 4'hc) begin
               addr_q     <= first_word[11:0];
               move_dst_q <= instr_word[11:0];
            end else begin
               target_q <= {1'b0, instr_word[11:0],
                            first_word[7:0]};
               fast_q   <= (first_word[15:9] == 7'b1110_110)
                           && first_word[`MIFD_FAST_BIT];
            end
         end else if (exec_go) begin
            dec_q        <= dec;
            addr_q       <= eff_addr;
            second_bad_q <= 1'b0;
            fast_q       <= 1'b0;
            result_q     <= next_result;
            skip_next    <= next_skip;
            taken_q      <= next_taken;
            // Extra cycle as a no-operation after a skip or a jump.
            cycles_q     <= (next_skip || next_taken)
                            ? `MIFD_CYC_TWO : `MIFD_CYC_ONE;
            if (dec.op == OP_JUMP) begin
               target_q <= {{10{instr_word[10]}},
                            instr_word[10:0]};
            end else if (dec.op == OP_BCOND) begin
               target_q <= {{13{instr_word[7]}},
                            instr_word[7:0]};
            end else begin
               target_q <= `MIFD_RST_PTR;
            end
            // A lone second word falls to the default: nothing written.
            if (next_to_file) begin
               file_wr_strobe <= 1'b1;
               file_wr_addr   <= eff_addr;
               file_wr_data   <= next_result;
            end
         end
      end
   end

   // Read decode; unmapped addresses answer with an error and zero data.
   always_comb begin
      prdata  = 32'h0000_0000;
      addr_ok = 1'b1;
      unique case (paddr)
         `MIFD_OFF_INSTR:   prdata = {16'h0000, instr_word};
         `MIFD_OFF_OPERAND: prdata = {24'h000000, operand};
         `MIFD_OFF_ACC:     prdata = {24'h000000, working_accumulator};
         `MIFD_OFF_BANK:    prdata = {28'h0000000, bank_select_reg};
         `MIFD_OFF_FLAGS:   prdata = {27'h0000000, flags};
         `MIFD_OFF_DECODE:  prdata = {dec_q.literal, 3'h0, dec_q.op,
                                      3'h0, dec_q.dest, dec_q.bank_acc,
                                      dec_q.bitpos, dec_q.faddr};
         `MIFD_OFF_ADDR:    prdata = {4'h0, move_dst_q, 4'h0, addr_q};
         `MIFD_OFF_TARGET:  prdata = {7'h00, fast_q, 3'h0, target_q};
         `MIFD_OFF_RESULT:  prdata = {17'h00000, (state == MIFD_WAIT2),
                                      second_bad_q, file_wr_strobe,
                                      cycles_q, taken_q, skip_next,
                                      result_q};
         `MIFD_OFF_PROGRAM_TABLE_POINTER:  prdata = {11'h000, program_table_pointer};
         `MIFD_OFF_TBLLAT:  prdata = {24'h000000, program_table_latch};
         default:           addr_ok = 1'b0;
      endcase
      pslverr = psel & penable & ~addr_ok;
   end

endmodule

// *** mifd_decoder_sva.sv ***
// Concurrent checks on the decoder's APB and execution ports.
`timescale 1ns/100ps
`include "mifd_params.svh"
module mifd_decoder_sva
   import mifd_pkg::*;
(
   // Clock and reset.
   input wire logic        clock,
   input wire logic        sys_rst,
   // APB.
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // Execution port.
   input wire logic        file_wr_strobe,
   input wire logic [11:0] file_wr_addr,
   input wire logic [7:0]  file_wr_data,
   input wire logic        skip_next
);
   // Decoded APB writes.
   wire wr = psel && penable && pwrite;
   wire iw = wr && paddr == `MIFD_OFF_INSTR;
   wire wo = wr && paddr == `MIFD_OFF_OPERAND;
   wire wa = wr && paddr == `MIFD_OFF_ACC;
   wire wb = wr && paddr == `MIFD_OFF_BANK;
   logic [7:0]  opv, accv;
   logic [3:0]  bnk;
   logic [15:0] wq;
   logic        fo, fa, fq;
   // Shadow copies of what software wrote last.
   always_ff @(posedge clock) begin
      if (wo) opv <= pwdata[7:0];
      if (wa) accv <= pwdata[7:0];
      if (iw) wq <= pwdata[15:0];
      bnk <= sys_rst ? `MIFD_RST_BANK : wb ? pwdata[3:0] : bnk;
   end
   // An instruction may rewrite the accumulator, so the shadow
   // copies are trusted only when both were written before this word.
   always_ff @(posedge clock) begin
      fo <= !sys_rst && (wo || (fo && !iw));
      fa <= !sys_rst && (wa || (fa && !iw));
      fq <= !sys_rst && (iw ? fo && fa : fq);
   end
   // Effective file address of the last word.
   wire [11:0] ea = wq[8] ? {bnk, wq[7:0]} :
      {wq[7] ? `MIFD_ACC_HIGH : `MIFD_ACC_LOW, wq[7:0]};

   default clocking cb @(posedge clock); endclocking
   default disable iff (sys_rst);

   AST_STROBE_ONE: assert property (
      file_wr_strobe |=> !file_wr_strobe)
      else $error("file strobe lasted more than a cycle");
   AST_STROBE_SRC: assert property (
      file_wr_strobe |-> $past(iw, 2))
      else $error("file strobe without an instruction");
   AST_DEST_ACC: assert property (
      iw && fo && pwdata[15:14] == 2'b00 && !pwdata[9]
      |-> ##2 !file_wr_strobe)
      else $error("file written with destination zero");
   AST_INC_DATA: assert property (
      file_wr_strobe && fq && wq[15:10] == 6'b001010
      |-> file_wr_data == opv + 8'h01)
      else $error("increment result wrong");
   AST_ADD_DATA: assert property (
      file_wr_strobe && fq && wq[15:10] == 6'b001001
      |-> file_wr_data == opv + accv)
      else $error("add result wrong");
   AST_CLR_DATA: assert property (
      file_wr_strobe && fq && wq[15:9] == 7'b0110101
      |-> file_wr_data == 8'h00)
      else $error("clear wrote non-zero");
   AST_FILE_ADDR: assert property (
      file_wr_strobe && fq |-> file_wr_addr == ea)
      else $error("file address wrong");
   AST_DEC_SKIP: assert property (
      $past(iw, 2) && fq && wq[15:10] == 6'b001011
      |-> skip_next == (opv == 8'h01))
      else $error("decrement skip on zero wrong");
   AST_NZ_SKIP: assert property (
      $past(iw, 2) && fq && wq[15:11] == 5'b01001
      |-> skip_next == (wq[10] ? opv != 8'h01 : opv != 8'hff))
      else $error("skip on non-zero wrong");
   AST_CMP_SKIP: assert property (
      $past(iw, 2) && fq && wq[15:11] == 5'b01100 && wq[10:9] != 2'b11
      |-> skip_next == (wq[10] ? opv > accv :
                        wq[9] ? opv == accv : opv < accv))
      else $error("compare skip wrong");

   COV_STROBE: cover property (file_wr_strobe);
   COV_SKIP: cover property ($rose(skip_next));
   COV_ERR: cover property (psel && penable && pslverr);
endmodule

// *** mifd_prog_mem.sv ***
// Program memory model holding the instruction words fed to the decoder.
`timescale 1ns/100ps
module mifd_prog_mem (
   // Word index.
   input  wire logic [4:0]  idx,
   // Instruction word.
   output logic      [15:0] word
);
   // Fixed program; an index past its end reads unknown on purpose, so a
   // stray fetch shows up instead of passing as a harmless word.
   localparam logic [15:0] ROM [0:22] = '{
      16'h2a85, 16'h2b10, 16'h2610, 16'h6b20,  // Inc, inc, add, clear.
      16'h2e30, 16'h4e30, 16'h4a30, 16'h3e30,  // Skip on count.
      16'h6230, 16'h6430, 16'h6030,            // Compares.
      16'hc123, 16'hf456,                      // Move pair.
      16'hed34, 16'hfabc,                      // Fast call pair.
      16'hd7ff, 16'he0fe, 16'hf000,            // Jumps, lone word.
      16'h2841, 16'h0630, 16'h8b47, 16'h0e7f,  // Dest 0, dec, bit, literal.
      16'h2210};                               // Add with carry.
   assign word = ROM[idx];
endmodule

// *** tb.sv ***
// Self-checking bench for the instruction format decoder.
`timescale 1ns/100ps
`include "mifd_params.svh"
module tb
   import mifd_pkg::*;
;
   logic        clock = 1'b0;
   logic        sys_rst = 1'b1;
   logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata;
   logic        pready, pslverr, file_wr_strobe, skip_next;
   logic [11:0] file_wr_addr;
   logic [7:0]  file_wr_data;
   logic [4:0]  pc = 5'h00;
   logic [15:0] iword;
   int          n_errors = 0, n_compared = 0, cyc = 0, n_strobe = 0;

   mifd_decoder uut (.clock, .sys_rst, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .file_wr_strobe, .file_wr_addr,
      .file_wr_data, .skip_next);
   mifd_prog_mem u_mem (.idx(pc), .word(iword));

   // Clock and hang guard; the run needs a few hundred cycles.
   always #5 clock = ~clock;
   always @(posedge clock) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_errors++;
         tally_and_finish;
      end
   end

   // Counts cycles with the file strobe high; the pulse is gone long before
   // a register read could see it, so this count is what the tests judge.
   always @(posedge clock) begin
      if (file_wr_strobe === 1'b1) n_strobe <= n_strobe + 1;
   end

   task automatic tally_and_finish;
      $display("compared %0d, mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, exp);
      n_compared++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // One APB transfer; an idle edge follows so strobes never double up.
   task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d, output logic [31:0] r, output logic e);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      @(posedge clock);
      while (pready !== 1'b1) @(posedge clock);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clock);
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic        e;
      apb(1'b1, a, d, r, e);
   endtask
   task automatic rdc(input logic [11:0] a, input logic [31:0] m, exp);
      logic [31:0] r;
      logic        e;
      apb(1'b0, a, 32'h0, r, e);
      chk(r & m, exp);
   endtask
   task automatic exec(input logic [4:0] i, input logic [7:0] f, a);
      pc = i;
      wr(`MIFD_OFF_OPERAND, {24'h0, f});
      wr(`MIFD_OFF_ACC, {24'h0, a});
      wr(`MIFD_OFF_INSTR, {16'h0, iword});
   endtask
   task automatic word2(input logic [4:0] i);
      pc = i;
      @(posedge clock);
      wr(`MIFD_OFF_INSTR, {16'h0, iword});
   endtask
   task automatic done(input string s);
      $display("test %s done", s);
   endtask

   task automatic t_reset;
      rdc(`MIFD_OFF_ACC, 32'hff, 32'h0);
      rdc(`MIFD_OFF_FLAGS, 32'h1f, 32'h0);
      rdc(`MIFD_OFF_PROGRAM_TABLE_POINTER, 32'h1fffff, 32'h0);
      done("reset");
   endtask
   task automatic t_inc;
      int s;
      wr(`MIFD_OFF_BANK, 32'h5);
      s = n_strobe;
      exec(5'd0, 8'hff, 8'h00);
      rdc(`MIFD_OFF_RESULT, 32'hff, 32'h0);
      chk(n_strobe - s, 32'h1);
      chk({20'h0, file_wr_addr}, 32'hf85);
      chk({24'h0, file_wr_data}, 32'h0);
      rdc(`MIFD_OFF_FLAGS, 32'h1f, 32'h07);
      rdc(`MIFD_OFF_ADDR, 32'hfff, 32'hf85);
      rdc(`MIFD_OFF_DECODE, 32'h1f1fff,
         {11'h0, OP_INC, 3'h0, 1'b1, 1'b0, 3'h5, 8'h85});
      exec(5'd1, 8'h10, 8'h00);
      rdc(`MIFD_OFF_ADDR, 32'hfff, 32'h510);
      done("increment");
   endtask
   task automatic t_arith;
      exec(5'd2, 8'h01, 8'h7f);
      rdc(`MIFD_OFF_RESULT, 32'hff, 32'h80);
      rdc(`MIFD_OFF_FLAGS, 32'h1f, 32'h1a);
      wr(`MIFD_OFF_FLAGS, 32'h01);
      exec(5'd22, 8'h0f, 8'hf0);
      rdc(`MIFD_OFF_FLAGS, 32'h1f, 32'h07);
      exec(5'd19, 8'h00, 8'h00);
      rdc(`MIFD_OFF_RESULT, 32'hff, 32'hff);
      rdc(`MIFD_OFF_FLAGS, 32'h1f, 32'h10);
      wr(`MIFD_OFF_FLAGS, 32'h1b);
      exec(5'd3, 8'h99, 8'h00);
      rdc(`MIFD_OFF_FLAGS, 32'h1f, 32'h1f);
      rdc(`MIFD_OFF_ADDR, 32'hfff, 32'h520);
      done("arith");
   endtask
   // Every skip opcode, both sides only for the decrement skips and less-than; flags must hold.
   task automatic t_skip;
      logic [4:0] ix [10] = '{4, 4, 5, 5, 6, 7, 8, 9, 10, 10};
      logic [7:0] fv [10] = '{1, 2, 1, 2, 8'hff, 8'hff, 51, 52, 52, 50};
      logic       sk [10] = '{1, 0, 0, 1, 0, 1, 1, 1, 0, 1};
      for (int k = 0; k < 10; k++) begin
         wr(`MIFD_OFF_FLAGS, 32'h15);
         exec(ix[k], fv[k], 8'd51);
         rdc(`MIFD_OFF_RESULT, 32'hd00, sk[k] ? 32'h900 : 32'h400);
         chk({31'h0, skip_next}, {31'h0, sk[k]});
         rdc(`MIFD_OFF_FLAGS, 32'h1f, 32'h15);
      end
      done("skip");
   endtask
   task automatic t_two_word;
      exec(5'd11, 8'h00, 8'h00);
      rdc(`MIFD_OFF_RESULT, 32'h4000, 32'h4000);
      word2(5'd12);
      rdc(`MIFD_OFF_ADDR, 32'h0fff0fff, 32'h04560123);
      exec(5'd13, 8'h00, 8'h00);
      word2(5'd14);
      rdc(`MIFD_OFF_TARGET, 32'h11fffff, 32'h10abc34);
      rdc(`MIFD_OFF_RESULT, 32'h6000, 32'h0);
      done("two word");
   endtask
   task automatic t_branch;
      int s;
      exec(5'd15, 8'h00, 8'h00);
      rdc(`MIFD_OFF_TARGET, 32'h1fffff, 32'h1fffff);
      rdc(`MIFD_OFF_RESULT, 32'hc00, 32'h800);
      exec(5'd16, 8'h00, 8'h00);
      rdc(`MIFD_OFF_TARGET, 32'h1fffff, 32'h1ffffe);
      s = n_strobe;
      exec(5'd17, 8'h00, 8'h5a);
      rdc(`MIFD_OFF_DECODE, 32'h1f0000, {11'h0, OP_SECOND, 16'h0});
      rdc(`MIFD_OFF_ACC, 32'hff, 32'h5a);
      rdc(`MIFD_OFF_RESULT, 32'h1100, 32'h0);
      chk(n_strobe - s, 32'h0);
      done("branch");
   endtask
   task automatic t_fields;
      int s;
      s = n_strobe;
      exec(5'd18, 8'h41, 8'h00);
      rdc(`MIFD_OFF_ACC, 32'hff, 32'h42);
      rdc(`MIFD_OFF_RESULT, 32'h1f00, 32'h400);
      chk(n_strobe - s, 32'h0);
      exec(5'd20, 8'h00, 8'h00);
      rdc(`MIFD_OFF_DECODE, 32'hfff, 32'hd47);
      exec(5'd21, 8'h00, 8'h00);
      rdc(`MIFD_OFF_DECODE, 32'hff000000, 32'h7f000000);
      done("fields");
   endtask
   task automatic t_regs;
      logic [31:0] r;
      logic        e;
      wr(`MIFD_OFF_PROGRAM_TABLE_POINTER, 32'hffffffff);
      rdc(`MIFD_OFF_PROGRAM_TABLE_POINTER, 32'hffffffff, 32'h1fffff);
      wr(`MIFD_OFF_TBLLAT, 32'h1ab);
      rdc(`MIFD_OFF_TBLLAT, 32'hffffffff, 32'hab);
      apb(1'b0, 12'h030, 32'h0, r, e);
      chk({r[30:0], e}, 32'h1);
      done("registers");
   endtask

   // Reset for four cycles, then run the scenarios.
   initial begin
      repeat (4) @(posedge clock);
      sys_rst <= 1'b0;
      @(posedge clock);
      t_reset;
      t_inc;
      t_arith;
      t_skip;
      t_two_word;
      t_branch;
      t_fields;
      t_regs;
      tally_and_finish;
   end
endmodule

bind mifd_decoder mifd_decoder_sva u_sva (.clock, .sys_rst, .psel,
   .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
   .file_wr_strobe, .file_wr_addr, .file_wr_data, .skip_next);
